// ### core/tps_pkg.sv
/*
 * tps_pkg: constants shared by the tributary protection switch core.
 * Assumes a 20 MHz system clock; all protection times count in 1 ms ticks.
 */
package tps_pkg;

    // sizes of the design
    localparam int NUM_TRIB = 4;
    localparam int TRIB_IDX_W = 2;
    localparam int INTERVAL_W = 16;
    localparam int RETRY_W = 8;
    localparam int WTR_W = 20;
    localparam int NODE_W = 8;
    localparam int TTYPE_W = 12;
    localparam int TNUM_W = 20;
    localparam int IDENT_W = NODE_W + TTYPE_W + TNUM_W;
    localparam int IDENT_BYTES = IDENT_W / 8;
    localparam int BYTE_CNT_W = 3;

    // timing: the tick period, then its length in clock cycles
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;

    // values after reset
    localparam logic [INTERVAL_W-1:0] INTERVAL_MS_RST = 16'h000a;
    localparam logic [RETRY_W-1:0] RETRY_RST = 8'h03;
    localparam int WTR_MINUTES = 10;
    localparam logic [WTR_W-1:0] WTR_MS_RST = WTR_W'(WTR_MINUTES * 60 * 1000);

    // protection request parameter
    localparam logic [5:0] CAST_RSVD = 6'h00;
    localparam logic [1:0] CAST_MULTI = 2'h1;

    // control frame opcodes
    localparam logic [7:0] OP_1P1_REQ = 8'h27;
    localparam logic [7:0] OP_1P1_RSP = 8'h28;
    localparam logic [7:0] OP_1T1_REQ = 8'h29;
    localparam logic [7:0] OP_1T1_RSP = 8'h2a;
    localparam logic [7:0] OP_1TN_REQ = 8'h2b;
    localparam logic [7:0] OP_1TN_RSP = 8'h2c;

    typedef enum logic [1:0] {
        TPS_SCHEME_1P1 = 2'b00,
        TPS_SCHEME_1T1 = 2'b01,
        TPS_SCHEME_1TN = 2'b10
    } tps_scheme_t;

    typedef enum logic [2:0] {
        TPS_MON_IDLE = 3'b000,
        TPS_MON_WATCH = 3'b001,
        TPS_MON_SWITCH = 3'b010,
        TPS_MON_PROT = 3'b011,
        TPS_MON_WTR = 3'b100
    } tps_mon_t;

    typedef enum logic [2:0] {
        TPS_SER_IDLE = 3'b000,
        TPS_SER_STBY = 3'b001,
        TPS_SER_CAST = 3'b010,
        TPS_SER_LEN = 3'b011,
        TPS_SER_WORK = 3'b100
    } tps_ser_t;

endpackage : tps_pkg

// ### core/tps_top.sv
/*
 * tps_top: tributary protection switch for one ring node.
 * Watches aggregate activity, moves flagged tributaries to standby,
 * reverts after wait-to-restore, reports recovery, and emits the
 * protection request parameter as a byte stream.
 * Assumes all inputs are synchronous to clk_sys_in.
 */
`timescale 1ns/1ps
module tps_top
    import tps_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // ring mac side
    input wire logic mac_frame_rx_in,
    input wire logic mac_status_ind_in,
    input wire logic [3:0] mac_status_opcode_in,
    // tributary side
    input wire logic [NUM_TRIB-1:0] standby_flag_in,
    input wire logic [NUM_TRIB-1:0] trib_normal_in,
    output logic [NUM_TRIB-1:0] fault_notice_out,
    output logic [NUM_TRIB-1:0] standby_sel_out,
    output logic [NUM_TRIB-1:0] alt_ringlet_out,
    // configuration
    input wire logic cfg_load_in,
    input wire logic [INTERVAL_W-1:0] cfg_interval_ms_in,
    input wire logic [RETRY_W-1:0] cfg_retry_in,
    input wire logic [WTR_W-1:0] cfg_wtr_ms_in,
    input wire logic [NODE_W-1:0] node_address_in,
    input wire logic [NUM_TRIB*TTYPE_W-1:0] tributary_type_in,
    input wire logic [NUM_TRIB*TNUM_W-1:0] tributary_number_in,
    // management report
    output logic report_valid_out,
    output logic [TTYPE_W-1:0] report_trib_type_out,
    output logic [TNUM_W-1:0] report_trib_num_out,
    // protection request stream
    input wire logic req_start_in,
    input wire logic req_response_in,
    input wire tps_scheme_t req_scheme_in,
    input wire logic [1:0] req_cast_in,
    input wire logic [TRIB_IDX_W-1:0] req_standby_idx_in,
    input wire logic [NUM_TRIB-1:0] req_working_mask_in,
    output logic req_busy_out,
    output logic req_valid_out,
    output logic req_last_out,
    output logic [7:0] req_byte_out,
    output logic [7:0] req_opcode_out,
    output logic [NUM_TRIB-1:0] req_dest_out
);
    localparam int TICK_W = $clog2(TICK_LEN + 1);

    logic [TICK_W-1:0] tick_cnt_q;
    logic tick_q;
    logic activity;
    logic [INTERVAL_W-1:0] interval_q;
    logic [RETRY_W-1:0] retry_q;
    logic [WTR_W-1:0] wtr_q;
    logic [NUM_TRIB-1:0] mon_fault;
    logic [NUM_TRIB-1:0] mon_standby;
    logic [NUM_TRIB-1:0] mon_restore;
    logic [NUM_TRIB-1:0] pend_q;
    logic [NUM_TRIB-1:0] pend_grant;
    tps_ser_t ser_q;
    logic [BYTE_CNT_W-1:0] byte_q;
    logic [NUM_TRIB-1:0] work_left_q;
    logic [TRIB_IDX_W-1:0] stby_q;
    logic [1:0] cast_q;
    logic [7:0] count_q;
    logic [TRIB_IDX_W-1:0] work_idx;
    logic [NUM_TRIB-1:0] work_bit;
    logic byte_end;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // identifier of a local tributary, node address first
    function automatic logic [IDENT_W-1:0] trib_ident(
        input logic [TRIB_IDX_W-1:0] idx,
        input logic [NODE_W-1:0] node,
        input logic [NUM_TRIB*TTYPE_W-1:0] types,
        input logic [NUM_TRIB*TNUM_W-1:0] nums
    );
        trib_ident = {node, types[idx*TTYPE_W +: TTYPE_W], nums[idx*TNUM_W +: TNUM_W]};
    endfunction : trib_ident

    // lowest set bit of a mask
    function automatic logic [TRIB_IDX_W-1:0] lowest_set(input logic [NUM_TRIB-1:0] mask);
        lowest_set = '0;
        for (int i = NUM_TRIB - 1; i >= 0; i--) begin
            if (mask[i]) begin
                lowest_set = TRIB_IDX_W'(i);
            end
        end
    endfunction : lowest_set

    // byte k of an identifier, most significant first
    function automatic logic [7:0] ident_byte(
        input logic [IDENT_W-1:0] ident,
        input logic [BYTE_CNT_W-1:0] k
    );
        ident_byte = ident[(IDENT_BYTES - 1 - int'(k)) * 8 +: 8];
    endfunction : ident_byte

    ////////////////////////////////////////////////////////////////////////
    // millisecond tick
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == TICK_W'(TICK_LEN - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
            tick_q <= 1'b0;
        end
    end

    // any of the four opcode flags makes a status indication count
    assign activity = mac_frame_rx_in || (mac_status_ind_in && (|mac_status_opcode_in));

    ////////////////////////////////////////////////////////////////////////
    // configuration, loaded as a set so the units always agree
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            interval_q <= INTERVAL_MS_RST;
            retry_q <= RETRY_RST;
            wtr_q <= WTR_MS_RST;
        end else if (cfg_load_in) begin
            interval_q <= cfg_interval_ms_in;
            retry_q <= cfg_retry_in;
            wtr_q <= cfg_wtr_ms_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one watcher per standby tributary
    generate
        for (genvar g = 0; g < NUM_TRIB; g++) begin : g_mon
            tps_trib_mon u_mon (
                .clk_sys_in(clk_sys_in),
                .rstn_in(rstn_in),
                .tick_in(tick_q),
                .activity_in(activity),
                .enable_in(standby_flag_in[g]),
                .trib_normal_in(trib_normal_in[g]),
                .interval_in(interval_q),
                .retry_in(retry_q),
                .wtr_in(wtr_q),
                .fault_notice_out(mon_fault[g]),
                .on_standby_out(mon_standby[g]),
                .restore_out(mon_restore[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fault_notice_out <= '0;
            standby_sel_out <= '0;
            alt_ringlet_out <= '0;
        end else begin
            fault_notice_out <= mon_fault;
            standby_sel_out <= mon_standby;
            alt_ringlet_out <= mon_standby;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // recovery reports; several may finish together, so they queue
    assign pend_grant = (pend_q != '0) ? (NUM_TRIB'(1) << lowest_set(pend_q)) : '0;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pend_q <= '0;
            report_valid_out <= 1'b0;
            report_trib_type_out <= '0;
            report_trib_num_out <= '0;
        end else begin
            // a new restore wins over the grant clearing the same bit
            pend_q <= (pend_q & ~pend_grant) | mon_restore;
            report_valid_out <= (pend_q != '0);
            if (pend_q != '0) begin
                report_trib_type_out <= tributary_type_in[lowest_set(pend_q)*TTYPE_W +: TTYPE_W];
                report_trib_num_out <= tributary_number_in[lowest_set(pend_q)*TNUM_W +: TNUM_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request parameter stream, one byte per cycle
    assign work_idx = lowest_set(work_left_q);
    assign work_bit = NUM_TRIB'(1) << work_idx;
    assign byte_end = (byte_q == BYTE_CNT_W'(IDENT_BYTES - 1));

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ser_q <= TPS_SER_IDLE;
            byte_q <= '0;
            work_left_q <= '0;
            stby_q <= '0;
            cast_q <= '0;
            count_q <= '0;
            req_busy_out <= 1'b0;
            req_valid_out <= 1'b0;
            req_last_out <= 1'b0;
            req_byte_out <= '0;
            req_opcode_out <= '0;
            req_dest_out <= '0;
        end else begin
            req_valid_out <= 1'b0;
            req_last_out <= 1'b0;
            case (ser_q)
                TPS_SER_IDLE: begin
                    req_busy_out <= 1'b0;
                    req_dest_out <= '0;
                    if (req_start_in) begin
                        stby_q <= req_standby_idx_in;
                        cast_q <= req_cast_in;
                        work_left_q <= req_working_mask_in;
                        count_q <= 8'($countones(req_working_mask_in));
                        byte_q <= '0;
                        req_busy_out <= 1'b1;
                        // every end addressed in the same frame
                        req_dest_out <= req_working_mask_in
                            | (NUM_TRIB'(1) << req_standby_idx_in);
                        case (req_scheme_in)
                            TPS_SCHEME_1P1: req_opcode_out <= req_response_in ? OP_1P1_RSP : OP_1P1_REQ;
                            TPS_SCHEME_1T1: req_opcode_out <= req_response_in ? OP_1T1_RSP : OP_1T1_REQ;
                            default: req_opcode_out <= req_response_in ? OP_1TN_RSP : OP_1TN_REQ;
                        endcase
                        ser_q <= TPS_SER_STBY;
                    end
                end
                TPS_SER_STBY: begin
                    req_valid_out <= 1'b1;
                    req_byte_out <= ident_byte(trib_ident(stby_q, node_address_in,
                        tributary_type_in, tributary_number_in), byte_q);
                    byte_q <= byte_end ? '0 : byte_q + BYTE_CNT_W'(1);
                    if (byte_end) begin
                        ser_q <= TPS_SER_CAST;
                    end
                end
                TPS_SER_CAST: begin
                    req_valid_out <= 1'b1;
                    req_byte_out <= {cast_q, CAST_RSVD};
                    ser_q <= TPS_SER_LEN;
                end
                TPS_SER_LEN: begin
                    req_valid_out <= 1'b1;
                    req_byte_out <= count_q;
                    req_last_out <= (work_left_q == '0);
                    ser_q <= (work_left_q == '0) ? TPS_SER_IDLE : TPS_SER_WORK;
                end
                TPS_SER_WORK: begin
                    req_valid_out <= 1'b1;
                    req_byte_out <= ident_byte(trib_ident(work_idx, node_address_in,
                        tributary_type_in, tributary_number_in), byte_q);
                    byte_q <= byte_end ? '0 : byte_q + BYTE_CNT_W'(1);
                    if (byte_end) begin
                        work_left_q <= work_left_q & ~work_bit;
                        if ((work_left_q & ~work_bit) == '0) begin
                            req_last_out <= 1'b1;
                            ser_q <= TPS_SER_IDLE;
                        end
                    end
                end
                default: begin
                    ser_q <= TPS_SER_IDLE;
                end
            endcase
        end
    end

endmodule : tps_top

// ### core/tps_trib_mon.sv
/*
 * tps_trib_mon: link watch, retry budget and wait-to-restore for one
 * standby tributary. Assumes a one-cycle tick_in every millisecond and
 * a one-cycle activity_in for each aggregate frame or flagged status indication.
 */
`timescale 1ns/1ps
module tps_trib_mon
    import tps_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // timing and aggregate
    input wire logic tick_in,
    input wire logic activity_in,
    // tributary side
    input wire logic enable_in,
    input wire logic trib_normal_in,
    // configuration
    input wire logic [INTERVAL_W-1:0] interval_in,
    input wire logic [RETRY_W-1:0] retry_in,
    input wire logic [WTR_W-1:0] wtr_in,
    // results
    output logic fault_notice_out,
    output logic on_standby_out,
    output logic restore_out
);
    tps_mon_t state_q;
    logic [INTERVAL_W-1:0] timer_q;
    logic [RETRY_W-1:0] retry_q;
    logic [WTR_W-1:0] wtr_q;
    logic seen_q;
    logic expire;
    logic quiet;
    logic fail;
    logic timing;

    assign timing = (state_q != TPS_MON_IDLE) && (state_q != TPS_MON_SWITCH);
    assign expire = timing && tick_in && (timer_q <= INTERVAL_W'(1));
    // activity in the expiring cycle still counts as seen
    assign quiet = expire && !seen_q && !activity_in;
    assign fail = quiet && (retry_q == '0);

    ////////////////////////////////////////////////////////////////////////
    // interval timer and retry budget, one set per tributary
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            timer_q <= INTERVAL_MS_RST;
            retry_q <= RETRY_RST;
            seen_q <= 1'b0;
        end else if (!timing) begin
            // held loaded so watching restarts fresh
            timer_q <= interval_in;
            retry_q <= retry_in;
            seen_q <= 1'b0;
        end else if (expire) begin
            timer_q <= interval_in;
            seen_q <= 1'b0;
            if (!quiet) begin
                retry_q <= retry_in;
            end else if (retry_q != '0) begin
                retry_q <= retry_q - RETRY_W'(1);
            end else begin
                retry_q <= retry_in;
            end
        end else begin
            if (tick_in) begin
                timer_q <= timer_q - INTERVAL_W'(1);
            end
            if (activity_in) begin
                seen_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection state
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= TPS_MON_IDLE;
            wtr_q <= WTR_MS_RST;
            fault_notice_out <= 1'b0;
            on_standby_out <= 1'b0;
            restore_out <= 1'b0;
        end else begin
            fault_notice_out <= 1'b0;
            restore_out <= 1'b0;
            if (!enable_in) begin
                state_q <= TPS_MON_IDLE;
                on_standby_out <= 1'b0;
            end else begin
                case (state_q)
                    TPS_MON_IDLE: begin
                        state_q <= TPS_MON_WATCH;
                    end
                    TPS_MON_WATCH: begin
                        if (fail) begin
                            fault_notice_out <= 1'b1;
                            on_standby_out <= 1'b1;
                            state_q <= TPS_MON_SWITCH;
                        end
                    end
                    TPS_MON_SWITCH: begin
                        if (trib_normal_in) begin
                            state_q <= TPS_MON_PROT;
                        end
                    end
                    TPS_MON_PROT: begin
                        if (activity_in) begin
                            wtr_q <= wtr_in;
                            state_q <= TPS_MON_WTR;
                        end
                    end
                    TPS_MON_WTR: begin
                        if (fail) begin
                            state_q <= TPS_MON_PROT;
                        end else if (tick_in && (wtr_q <= WTR_W'(1))) begin
                            on_standby_out <= 1'b0;
                            restore_out <= 1'b1;
                            state_q <= TPS_MON_WATCH;
                        end else if (tick_in) begin
                            wtr_q <= wtr_q - WTR_W'(1);
                        end
                    end
                    default: begin
                        state_q <= TPS_MON_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : tps_trib_mon

// ### verification/test_tributary_protection_switch.sv
/*
 * test_tributary_protection_switch: scenario bench for tps_top.
 * Assumes tps_mac_model as ring mac and a tick shortened to 10 cycles.
 */
`timescale 1ns/1ps
module test_tributary_protection_switch;
    import tps_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    wire logic mac_frame_rx_in, mac_status_ind_in;
    wire logic [3:0] mac_status_opcode_in;
    logic [1:0] mac_mode = 2'h0;
    logic [NUM_TRIB-1:0] standby_flag_in = 4'h1, trib_normal_in = 4'h0;
    logic [NUM_TRIB-1:0] fault_notice_out, standby_sel_out, alt_ringlet_out, req_dest_out;
    logic cfg_load_in = 1'b0;
    logic [INTERVAL_W-1:0] cfg_interval_ms_in = 16'h0004;
    logic [RETRY_W-1:0] cfg_retry_in = 8'h01;
    logic [WTR_W-1:0] cfg_wtr_ms_in = 20'h00014;
    logic [NODE_W-1:0] node_address_in = 8'h05;
    logic [NUM_TRIB*TTYPE_W-1:0] tributary_type_in = 48'h7a13c4e5209b;
    logic [NUM_TRIB*TNUM_W-1:0] tributary_number_in = 80'h8d2f100000fffff4b6c3;
    logic report_valid_out, req_busy_out, req_valid_out, req_last_out;
    logic [TTYPE_W-1:0] report_trib_type_out;
    logic [TNUM_W-1:0] report_trib_num_out;
    logic req_start_in = 1'b0, req_response_in = 1'b0;
    tps_scheme_t req_scheme_in = TPS_SCHEME_1P1;
    logic [1:0] req_cast_in = 2'h0, req_standby_idx_in = 2'h0;
    logic [NUM_TRIB-1:0] req_working_mask_in = 4'h2;
    logic [7:0] req_byte_out, req_opcode_out;
    logic [7:0] got_q[$], exp_q[$];
    int n_mismatch = 0, total_checks = 0, n_flt, n_rep;

    always #25 clk_sys_in = ~clk_sys_in;
    tps_top #(.TICK_LEN(10)) tps_top_inst (.*);
    tps_mac_model tps_mac_model_inst (.clk_sys_in, .rstn_in, .mode_in(mac_mode),
        .frame_out(mac_frame_rx_in), .status_out(mac_status_ind_in),
        .opcode_out(mac_status_opcode_in));
    ////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step();
        @(posedge clk_sys_in);
        #1;
    endtask : step
    function automatic logic [39:0] ident(input int i);
        return {node_address_in, tributary_type_in[i*TTYPE_W +: TTYPE_W],
            tributary_number_in[i*TNUM_W +: TNUM_W]};
    endfunction : ident
    task automatic push_id(input int i);
        logic [39:0] id;
        id = ident(i);
        for (int b = 4; b >= 0; b--) exp_q.push_back(id[b*8 +: 8]);
    endtask : push_id
    // counts fault notices of tributary 0 and reports while the mac runs in a mode
    task automatic run(input int n, input logic [1:0] mode);
        mac_mode = mode;
        n_flt = 0;
        n_rep = 0;
        repeat (n) begin
            step();
            n_flt += int'(fault_notice_out[0] === 1'b1);
            n_rep += int'(report_valid_out === 1'b1);
        end
    endtask : run
    task automatic wait_fault(input int i, input int lo, input int hi);
        int c;
        c = 0;
        while (fault_notice_out[i] !== 1'b1 && c < hi + 20) begin
            step();
            c++;
        end
        chk(c >= lo && c <= hi, 1'b1);
        chk(standby_sel_out[i], 1'b1);
    endtask : wait_fault
    ////////////////////////////////////////
    task automatic t_defaults();
        repeat (200) step();
        standby_flag_in = 4'h5;
        wait_fault(0, 185, 225);
        chk(alt_ringlet_out, 4'h1);
        wait_fault(2, 180, 225);
    endtask : t_defaults
    task automatic t_restore();
        int k;
        cfg_load_in = 1'b1;
        step();
        cfg_load_in = 1'b0;
        trib_normal_in = 4'h5;
        run(180, 2'h1);
        chk(standby_sel_out, 4'h5);
        chk(n_rep, 0);
        k = 0;
        repeat (80) begin
            step();
            if (report_valid_out === 1'b1) begin
                chk({report_trib_type_out, report_trib_num_out}, ident(k) & 40'hffffffffff >> 8);
                chk(standby_sel_out[k], 1'b0);
                k += 2;
            end
        end
        chk(k, 4);
    endtask : t_restore
    task automatic t_activity();
        run(300, 2'h1);
        chk(n_flt, 0);
        run(300, 2'h2);
        chk(n_flt, 0);
        mac_mode = 2'h3;
        wait_fault(0, 30, 130);
        // a short burst starts the restore wait, then silence must cancel it
        run(40, 2'h1);
        run(300, 2'h0);
        chk(standby_sel_out[0], 1'b1);
        chk(n_rep, 0);
    endtask : t_activity
    task automatic t_stream();
        for (int s = 0; s < 6; s++) begin
            req_scheme_in = tps_scheme_t'(s / 2);
            req_response_in = s[0];
            req_standby_idx_in = 2'(s);
            req_working_mask_in = (s >= 4) ? 4'hf & ~(4'h1 << s[1:0]) : 4'h1 << ((s + 1) % 4);
            req_cast_in = (s >= 4) ? CAST_MULTI : 2'h0;
            exp_q.delete();
            got_q.delete();
            push_id(s % 4);
            exp_q.push_back({req_cast_in, CAST_RSVD});
            exp_q.push_back(8'($countones(req_working_mask_in)));
            for (int t = 0; t < 4; t++) if (req_working_mask_in[t]) push_id(t);
            req_start_in = 1'b1;
            step();
            req_start_in = 1'b0;
            repeat (26) begin
                step();
                if (req_valid_out === 1'b1) begin
                    got_q.push_back(req_byte_out);
                    chk(req_last_out, got_q.size() == exp_q.size());
                end
                req_start_in = (got_q.size() == 3);
                if (req_busy_out === 1'b1) begin
                    chk(req_opcode_out, 8'h27 + 8'(s));
                    chk(req_dest_out, req_working_mask_in | (4'h1 << s[1:0]));
                end
            end
            chk(got_q.size(), exp_q.size());
            foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
        end
    endtask : t_stream
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_sys_in);
        #1;
        rstn_in = 1'b1;
        t_defaults();
        t_restore();
        t_activity();
        t_stream();
        end_of_test();
    end
    // the scenarios need about 2100 cycles
    initial begin
        #(20000 * 50);
        n_mismatch++;
        end_of_test();
    end
endmodule : test_tributary_protection_switch

// ### verification/tps_mac_model.sv
/*
 * tps_mac_model: ring mac stand-in, one pulse every 32 cycles in modes 1 to 3.
 * Assumes mode 0 silent, 1 frames, 2 flagged status, 3 status with no flag.
 */
`timescale 1ns/1ps
module tps_mac_model (
    // clock, reset and mode
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [1:0] mode_in,
    // mac indications
    output logic frame_out,
    output logic status_out,
    output logic [3:0] opcode_out
);
    logic [6:0] cnt_q = 7'h00;
    // changes land 1 ns after the edge, like the bench's own drive
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frame_out <= #1 1'b0;
            status_out <= #1 1'b0;
            opcode_out <= #1 4'h0;
        end else begin
            cnt_q <= cnt_q + 7'h01;
            frame_out <= #1 (mode_in == 2'h1) && (cnt_q[4:0] == 5'h00);
            status_out <= #1 mode_in[1] && (cnt_q[4:0] == 5'h00);
            // walks all four status flags; mode 3 sends an indication carrying none
            opcode_out <= #1 mode_in[0] ? 4'h0 : 4'h1 << cnt_q[6:5];
        end
    end
endmodule : tps_mac_model

// ### verification/tps_top_properties.sv
/*
 * tps_top_properties: concurrent checks on the ports of tps_top.
 * Assumes one clock domain and inputs driven just after the rising edge.
 */
`timescale 1ns/1ps
module tps_top_properties
    import tps_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // tributary side
    input wire logic [NUM_TRIB-1:0] standby_flag_in,
    input wire logic [NUM_TRIB-1:0] fault_notice_out,
    input wire logic [NUM_TRIB-1:0] standby_sel_out,
    input wire logic [NUM_TRIB-1:0] alt_ringlet_out,
    input wire logic report_valid_out,
    // request stream
    input wire logic req_start_in,
    input wire logic req_busy_out,
    input wire logic req_valid_out,
    input wire logic req_last_out,
    input wire logic [7:0] req_opcode_out,
    input wire logic [NUM_TRIB-1:0] req_dest_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////
    a_ringlet_follows: assert property (alt_ringlet_out == standby_sel_out)
        else $error("ringlet select differs from standby select");
    a_notice_single: assert property ((fault_notice_out & $past(fault_notice_out)) == '0)
        else $error("fault notice longer than one cycle");
    a_notice_flagged: assert property (fault_notice_out != '0 |->
        (fault_notice_out & ~$past(standby_flag_in, 3)) == '0)
        else $error("fault notice to an unflagged tributary");
    a_notice_standby: assert property ((fault_notice_out & ~standby_sel_out) == '0)
        else $error("fault notice without standby select");
    // a drop caused by the flag going low is not a reversion
    a_revert_reports: assert property (((($past(standby_sel_out) & ~standby_sel_out)
        & standby_flag_in & $past(standby_flag_in)) != '0) |-> ##[0:8] report_valid_out)
        else $error("reversion without restore report");
    a_stream_start: assert property (req_start_in && !req_busy_out && !req_valid_out
        |=> req_busy_out ##1 req_valid_out [*5])
        else $error("stream did not start with five ident bytes");
    a_bytes_contig: assert property ($fell(req_valid_out) |-> $past(req_last_out))
        else $error("stream stopped before its last byte");
    a_last_inside: assert property (req_last_out |-> req_valid_out && req_busy_out)
        else $error("last flag outside a stream byte");
    // a start taken right after the last byte may load a new destination
    a_dest_held: assert property (req_busy_out && $past(req_busy_out) && !$past(req_last_out)
        |-> $stable(req_dest_out) && $stable(req_opcode_out))
        else $error("destination or opcode moved during stream");
    a_quiet_reset: assert property (!$past(rstn_in)
        |-> fault_notice_out == '0 && standby_sel_out == '0 && !report_valid_out)
        else $error("outputs active at first edge after reset");
endmodule : tps_top_properties

bind tps_top tps_top_properties tps_top_properties_inst (.*);
